//--- feature_enable_pkg.sv
// Constants for the extended feature enable register
package feature_enable_pkg;

  // ----------------------------------------------------------------
  // Register address and width
  // ----------------------------------------------------------------
  localparam int unsigned FEAT_DATA_W = 64;
  localparam logic [31:0] FEAT_REG_ADDR = 32'hc0000080;
  localparam logic [63:0] FEAT_RESET_VAL = 64'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CALL_EXT_POS = 0;
  localparam int unsigned LONG_EN_POS = 8;
  localparam int unsigned RSV9_POS = 9;
  localparam int unsigned LONG_ACT_POS = 10;
  localparam int unsigned NOEXEC_POS = 11;
  localparam int unsigned VM_EN_POS = 12;
  localparam int unsigned SEG_LIM_POS = 13;
  localparam int unsigned FP_SAVE_POS = 14;
  localparam int unsigned RSV_HI_LSB = 15;

  // ----------------------------------------------------------------
  // Masks
  // ----------------------------------------------------------------
  // Bits that must be written as zero (63..15 and 9)
  localparam logic [63:0] MBZ_MASK = 64'hffff_ffff_ffff_8200;
  // Bits that always read as zero (63..15, 9 and 7..1)
  localparam logic [63:0] READ_ZERO_MASK = 64'hffff_ffff_ffff_82fe;
  // Fault error code reported on a refused write
  localparam logic [31:0] FAULT_CODE_VAL = 32'h0;

endpackage

//--- feature_write_check.sv
// Write legality check for the extended feature enable register
`timescale 1ns/1ps

module feature_write_check
  import feature_enable_pkg::*;
(
  input wire logic [63:0] wdata, // Data software tries to write
  input wire logic long_act_now, // Current long-mode-active status
  output logic status_change, // Write would alter the status bit
  output logic mbz_violation // Write sets a must-be-zero bit
);

  // ----------------------------------------------------------------
  // Combinational checks
  // ----------------------------------------------------------------
  // Status bit compare and reserved-bit screen
  always_comb begin
    status_change = (wdata[LONG_ACT_POS] != long_act_now); // RULE4
    mbz_violation = |(wdata & MBZ_MASK); // RULE9
  end

endmodule // feature_write_check

//--- extended_feature_enable_reg.sv
// Extended feature enable register with long-mode status and write fault
`timescale 1ns/1ps

// Behaviour
// [RULE1] Bit 0 enables system call extension
// [RULE2] Bit 8 requests long mode, resets zero
// [RULE3] Bit 10 read-only long mode active status
// [RULE4] Write changing bit 10 raises fault, code 0
// [RULE5] Bit 11 enables no-execute paging
// [RULE6] Bit 12 enables virtual machine support
// [RULE7] Bit 13 enables long-mode segment limit checks
// [RULE8] Bit 14 enables fast floating-point save
// [RULE9] Reserved bits read zero, must be zero
// [RULE10] Software checks identification flag before fast save
// [RULE11] Software sets fast save once only
// [RULE12] Firmware leaves register alone unless needed
// [RULE13] Good write updates all; read returns state
module extended_feature_enable_reg
  import feature_enable_pkg::*;
(
  input wire logic clk, // Core clock, 125 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic msr_wr_en, // One-cycle write request
  input wire logic msr_rd_en, // One-cycle read request
  input wire logic [31:0] msr_addr, // Register address of the request
  input wire logic [63:0] msr_wdata, // Write data
  input wire logic long_mode_active_in, // Long mode status from core logic
  output logic [63:0] msr_rdata, // Read data, valid with msr_rd_valid
  output logic msr_rd_valid, // Pulse: read answered
  output logic msr_wr_done, // Pulse: write accepted
  output logic general_protection_fault, // Pulse: write refused
  output logic [31:0] fault_error_code, // Error code with the fault
  output logic fast_system_call_enable, // Feature enable outputs
  output logic long_mode_enable,
  output logic long_mode_active,
  output logic no_execute_enable,
  output logic virtual_machine_support_enable,
  output logic segment_limit_check_enable,
  output logic fast_fp_state_save_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic call_ext_ff, nxt_call_ext; // System call enable
  logic long_en_ff, nxt_long_en; // Long mode enable
  logic long_act_ff, nxt_long_act; // Long mode active status
  logic noexec_ff, nxt_noexec; // No-execute enable
  logic vm_en_ff, nxt_vm_en; // Virtual machine enable
  logic seg_lim_ff, nxt_seg_lim; // Segment limit check enable
  logic fp_save_ff, nxt_fp_save; // Fast save enable
  logic [63:0] rdata_ff, nxt_rdata; // Read data holding
  logic rd_valid_ff, nxt_rd_valid; // Read answer pulse
  logic wr_done_ff, nxt_wr_done; // Write accepted pulse
  logic fault_ff, nxt_fault; // Fault pulse
  logic [31:0] ecode_ff, nxt_ecode; // Fault error code

  // Decode and checks
  logic addr_hit; // Request targets this register
  logic wr_hit; // Write to this register
  logic rd_hit; // Read of this register
  logic status_change; // Write would alter status bit
  logic mbz_violation; // Write sets reserved bits
  logic wr_ok; // Write is legal
  logic [63:0] cur_value; // Register image as software sees it

  // ----------------------------------------------------------------
  // Write checker
  // ----------------------------------------------------------------
  feature_write_check feature_write_check_inst (
    .wdata(msr_wdata),
    .long_act_now(long_act_ff),
    .status_change(status_change),
    .mbz_violation(mbz_violation)
  );

  // ----------------------------------------------------------------
  // Address decode and register image
  // ----------------------------------------------------------------
  // Reserved positions are left at zero in the image
  always_comb begin
    addr_hit = (msr_addr == FEAT_REG_ADDR);
    wr_hit = msr_wr_en && addr_hit;
    rd_hit = msr_rd_en && addr_hit;
    wr_ok = !status_change && !mbz_violation;
    cur_value = FEAT_RESET_VAL; // RULE9
    cur_value[CALL_EXT_POS] = call_ext_ff;
    cur_value[LONG_EN_POS] = long_en_ff;
    cur_value[LONG_ACT_POS] = long_act_ff;
    cur_value[NOEXEC_POS] = noexec_ff;
    cur_value[VM_EN_POS] = vm_en_ff;
    cur_value[SEG_LIM_POS] = seg_lim_ff;
    cur_value[FP_SAVE_POS] = fp_save_ff;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Enables load together on a legal write; status follows core
  always_comb begin
    nxt_call_ext = call_ext_ff;
    nxt_long_en = long_en_ff;
    nxt_noexec = noexec_ff;
    nxt_vm_en = vm_en_ff;
    nxt_seg_lim = seg_lim_ff;
    nxt_fp_save = fp_save_ff;
    nxt_long_act = long_mode_active_in; // RULE3
    nxt_rdata = rdata_ff;
    nxt_rd_valid = 1'b0;
    nxt_wr_done = 1'b0;
    nxt_fault = 1'b0;
    nxt_ecode = ecode_ff;
    if (wr_hit && wr_ok) begin
      // Legal write: every writable enable updates at once
      nxt_call_ext = msr_wdata[CALL_EXT_POS]; // RULE1 RULE13
      nxt_long_en = msr_wdata[LONG_EN_POS]; // RULE2
      nxt_noexec = msr_wdata[NOEXEC_POS]; // RULE5
      nxt_vm_en = msr_wdata[VM_EN_POS]; // RULE6
      nxt_seg_lim = msr_wdata[SEG_LIM_POS]; // RULE7
      nxt_fp_save = msr_wdata[FP_SAVE_POS]; // RULE8
      nxt_wr_done = 1'b1;
    end else if (wr_hit) begin
      // Refused write: fault with code zero, nothing stored
      nxt_fault = 1'b1; // RULE4
      nxt_ecode = FAULT_CODE_VAL; // RULE4
    end
    if (rd_hit) begin
      // Read returns current image
      nxt_rdata = cur_value; // RULE13
      nxt_rd_valid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All fields clear on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      call_ext_ff <= 1'b0;
      long_en_ff <= 1'b0;
      long_act_ff <= 1'b0;
      noexec_ff <= 1'b0;
      vm_en_ff <= 1'b0;
      seg_lim_ff <= 1'b0;
      fp_save_ff <= 1'b0;
      rdata_ff <= 64'h0;
      rd_valid_ff <= 1'b0;
      wr_done_ff <= 1'b0;
      fault_ff <= 1'b0;
      ecode_ff <= 32'h0;
    end else begin
      call_ext_ff <= nxt_call_ext;
      long_en_ff <= nxt_long_en;
      long_act_ff <= nxt_long_act;
      noexec_ff <= nxt_noexec;
      vm_en_ff <= nxt_vm_en;
      seg_lim_ff <= nxt_seg_lim;
      fp_save_ff <= nxt_fp_save;
      rdata_ff <= nxt_rdata;
      rd_valid_ff <= nxt_rd_valid;
      wr_done_ff <= nxt_wr_done;
      fault_ff <= nxt_fault;
      ecode_ff <= nxt_ecode;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Each output is a flip-flop
  assign msr_rdata = rdata_ff;
  assign msr_rd_valid = rd_valid_ff;
  assign msr_wr_done = wr_done_ff;
  assign general_protection_fault = fault_ff;
  assign fault_error_code = ecode_ff;
  assign fast_system_call_enable = call_ext_ff;
  assign long_mode_enable = long_en_ff;
  assign long_mode_active = long_act_ff;
  assign no_execute_enable = noexec_ff;
  assign virtual_machine_support_enable = vm_en_ff;
  assign segment_limit_check_enable = seg_lim_ff;
  assign fast_fp_state_save_enable = fp_save_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  call_ext_load_a: assert property ( // RULE1
    wr_hit && wr_ok |=> call_ext_ff == $past(msr_wdata[CALL_EXT_POS]))
    else $error("system call enable not loaded");

  long_en_load_a: assert property ( // RULE2
    wr_hit && wr_ok |=> long_en_ff == $past(msr_wdata[LONG_EN_POS]))
    else $error("long mode enable not loaded");

  status_follows_a: assert property ( // RULE3
    1'b1 |=> long_act_ff == $past(long_mode_active_in))
    else $error("long mode active not tracking core");

  fault_raise_a: assert property ( // RULE4
    wr_hit && (msr_wdata[LONG_ACT_POS] != long_act_ff) |=> fault_ff &&
      ecode_ff == FAULT_CODE_VAL && !wr_done_ff)
    else $error("status change write did not fault");

  fault_keeps_a: assert property ( // RULE4
    fault_ff |-> {call_ext_ff, long_en_ff, noexec_ff, vm_en_ff, seg_lim_ff, fp_save_ff} ==
      $past({call_ext_ff, long_en_ff, noexec_ff, vm_en_ff, seg_lim_ff, fp_save_ff}))
    else $error("refused write changed enables");

  noexec_vm_load_a: assert property ( // RULE5 RULE6
    wr_hit && wr_ok |=> noexec_ff == $past(msr_wdata[NOEXEC_POS]) &&
      vm_en_ff == $past(msr_wdata[VM_EN_POS]))
    else $error("no-execute or vm enable not loaded");

  limit_fp_load_a: assert property ( // RULE7 RULE8
    wr_hit && wr_ok |=> seg_lim_ff == $past(msr_wdata[SEG_LIM_POS]) &&
      fp_save_ff == $past(msr_wdata[FP_SAVE_POS]))
    else $error("segment limit or fast save enable not loaded");

  reserved_zero_a: assert property ( // RULE9
    rd_valid_ff |-> (rdata_ff & READ_ZERO_MASK) == 64'h0)
    else $error("reserved bits read nonzero");

  read_value_a: assert property ( // RULE13
    rd_hit |=> rd_valid_ff && rdata_ff[LONG_ACT_POS] == $past(long_act_ff) &&
      rdata_ff[CALL_EXT_POS] == $past(call_ext_ff) &&
      rdata_ff[FP_SAVE_POS] == $past(fp_save_ff))
    else $error("read data does not match register");

  legal_write_a: assert property ( // RULE13
    wr_hit && wr_ok |=> wr_done_ff && !fault_ff ##1 !wr_done_ff || $past(wr_hit && wr_ok))
    else $error("legal write not acknowledged");

  good_write_c: cover property (wr_hit && wr_ok ##1 wr_done_ff);
  fault_write_c: cover property (wr_hit && status_change ##1 fault_ff);
  status_read_c: cover property (long_act_ff && rd_hit ##1 rd_valid_ff);
  mbz_write_c: cover property (wr_hit && mbz_violation && !status_change);

endmodule // extended_feature_enable_reg

//--- extended_feature_enable_reg_tb.sv
// Self-checking bench for the extended feature enable register
`timescale 1ns/1ps

module extended_feature_enable_reg_tb;
  import feature_enable_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, outputs and expectation state
  // ----------------------------------------------------------------
  localparam logic [63:0] WR_MASK = 64'h0000_0000_0000_7901; // Writable enables
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic act_in = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [63:0] wdata = 64'h0;
  logic [63:0] rdata;
  logic [31:0] ecode;
  logic rd_valid, wr_done, gpf, sc, lm_en, act, nx, vm, seg, fp;
  logic fp_save_present = 1'b1; // Identification flag software consults
  logic [65:0] notes[$]; // Kind in top two bits, expected value below
  logic [63:0] img = 64'h0; // Expected writable bits
  logic exp_act = 1'b0; // Expected status bit
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'hbf3f;
  wire [63:0] outs = {49'h0, fp, seg, vm, nx, act, 1'b0, lm_en, 7'h0, sc};

  // Clock, 8 ns period
  always #4 clk = ~clk;

  extended_feature_enable_reg extended_feature_enable_reg_inst (
    .clk(clk), .reset_n(reset_n), .msr_wr_en(wr_en), .msr_rd_en(rd_en),
    .msr_addr(addr), .msr_wdata(wdata), .long_mode_active_in(act_in),
    .msr_rdata(rdata), .msr_rd_valid(rd_valid), .msr_wr_done(wr_done),
    .general_protection_fault(gpf), .fault_error_code(ecode),
    .fast_system_call_enable(sc), .long_mode_enable(lm_en), .long_mode_active(act),
    .no_execute_enable(nx), .virtual_machine_support_enable(vm),
    .segment_limit_check_enable(seg), .fast_fp_state_save_enable(fp)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    check(64'(notes.size()), 64'h0);
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One request cycle; notes the expected answers
  task automatic req(input logic w, input logic r, input logic [31:0] a,
                     input logic [63:0] d);
    logic bad;
    @(posedge clk);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    bad = (d[10] != exp_act) || ((d & MBZ_MASK) != 64'h0);
    if (a == FEAT_REG_ADDR) begin
      // Read sees the image before a same-cycle write
      if (r) notes.push_back({2'd0, img | (64'(exp_act) << 10)});
      if (w && !bad) img = d & WR_MASK;
      if (w) notes.push_back({bad ? 2'd2 : 2'd1, img | (64'(exp_act) << 10)});
    end
  endtask

  // Drop requests
  task automatic idle();
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  // Change core status and let it settle
  task automatic set_act(input logic v);
    idle();
    act_in <= v;
    repeat (3) @(posedge clk);
    exp_act = v;
  endtask

  // Match one answer pulse with the oldest note
  task automatic take(input logic [1:0] k, input logic [63:0] got);
    logic [65:0] n;
    n = (notes.size() != 0) ? notes.pop_front() : {2'd3, 64'h0};
    check({62'h0, k}, {62'h0, n[65:64]});
    check(got, n[63:0]);
  endtask

  // ----------------------------------------------------------------
  // Output watcher and timeout
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    cycles++;
    if (rd_valid === 1'b1) take(2'd0, rdata);
    if (wr_done === 1'b1) take(2'd1, outs);
    if (gpf === 1'b1) begin
      take(2'd2, outs);
      check(64'(ecode), 64'(FAULT_CODE_VAL));
    end
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] d;
    static int pos[6] = '{0, 8, 11, 12, 13, 14};
    static int bpos[4] = '{9, 15, 40, 63};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check(outs, 64'h0);
    req(1'b0, 1'b1, FEAT_REG_ADDR, 64'h0);
    // Each enable alone, read back
    foreach (pos[i]) begin
      if (pos[i] == FP_SAVE_POS && !fp_save_present) continue;
      req(1'b1, 1'b0, FEAT_REG_ADDR, 64'h1 << pos[i]);
      req(1'b0, 1'b1, FEAT_REG_ADDR, 64'h0);
    end
    // Low reserved bits ignored
    req(1'b1, 1'b1, FEAT_REG_ADDR, 64'h0000_0000_0000_79fe);
    req(1'b0, 1'b1, FEAT_REG_ADDR, 64'h0);
    // Must-be-zero bits refused
    foreach (bpos[i]) req(1'b1, 1'b1, FEAT_REG_ADDR, 64'h1 << bpos[i]);
    // Status bit cannot be changed by software
    req(1'b1, 1'b0, FEAT_REG_ADDR, 64'h0000_0000_0000_0400);
    set_act(1'b1);
    req(1'b1, 1'b1, FEAT_REG_ADDR, 64'h0000_0000_0000_0101);
    req(1'b1, 1'b1, FEAT_REG_ADDR, 64'h0000_0000_0000_4500);
    // Unmapped address gives no answer
    req(1'b1, 1'b1, FEAT_REG_ADDR ^ 32'h1, '1);
    req(1'b0, 1'b1, FEAT_REG_ADDR, 64'h0);
    // Random back-to-back traffic, status flipped between rounds
    repeat (2) begin
      repeat (300) begin
        d = {$random(seed), $random(seed)};
        if (d[0]) d = (d & ~MBZ_MASK & ~64'h400) | (64'(exp_act) << 10);
        d[FP_SAVE_POS] = img[FP_SAVE_POS];
        req(d[1], d[2] | ~d[1], d[5:3] != 3'h0 ? FEAT_REG_ADDR : d[63:32], d);
      end
      set_act(~exp_act);
    end
    // Reset in mid-run clears everything
    set_act(1'b0);
    idle();
    reset_n <= 1'b0;
    img = 64'h0;
    @(negedge clk);
    check(outs, 64'h0);
    check(rdata, 64'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    req(1'b0, 1'b1, FEAT_REG_ADDR, 64'h0);
    idle();
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // extended_feature_enable_reg_tb
